/* File: verilog/sdo_pkg.sv */
// shared constants of the receive video output port
package sdo_pkg;
  // receiver mode codes on the mode input
  localparam logic [1:0] MODE_HD = 2'h0;
  localparam logic [1:0] MODE_SD = 2'h1;
  localparam logic [1:0] MODE_3G = 2'h2;
  // timing reference words
  localparam logic [9:0] TRS_ONES = 10'h3ff;
  localparam logic [9:0] TRS_ZERO = 10'h000;
  localparam int XYZ_H_BIT = 6;
  // line number word fields
  localparam int LN0_LSB = 2;
  localparam int LN0_MSB = 8;
  localparam int LN1_LSB = 2;
  localparam int LN1_MSB = 5;
  // crc-18 reflected feedback mask and word field width
  localparam logic [17:0] CRC_MASK = 18'h26000;
  localparam int CRC_HALF = 9;
  // samples after the eav sample: ln0, ln1, crc0, crc1, flag change
  localparam logic [2:0] PC_LN0 = 3'h1;
  localparam logic [2:0] PC_LN1 = 3'h2;
  localparam logic [2:0] PC_CRC0 = 3'h3;
  localparam logic [2:0] PC_CRC1 = 3'h4;
  localparam logic [2:0] PC_ERR = 3'h6;
  // payload id packet header words (low eight bits)
  localparam logic [7:0] ANC_DID = 8'h41;
  localparam logic [7:0] ANC_SDID = 8'h01;
  localparam logic [7:0] ANC_DC = 8'h04;
  localparam logic [2:0] VPID_BYTES = 3'h4;
  // sd sample cadence: two enables per eleven clocks
  localparam logic [3:0] SD_PERIOD_LAST = 4'ha;
  localparam logic [3:0] SD_SECOND = 4'h5;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LINE = 8'h08;
  localparam logic [7:0] REG_VPID_A = 8'h0c;
  localparam logic [7:0] REG_VPID_B = 8'h10;
  // control field and reset value
  localparam int CTRL_FRAME_BIT = 0;
  localparam logic CTRL_FRAME_RST = 1'b1;
  // status field positions
  localparam int ST_MLOCK = 0;
  localparam int ST_TLOCK = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_LEVB = 4;
  localparam int ST_NSP = 5;
  localparam int ST_CRCA = 6;
  localparam int ST_CRCB = 7;
  localparam int ST_VVA = 8;
  localparam int ST_VVB = 9;
  localparam int LINE_B_LSB = 16;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : sdo_pkg

/* File: verilog/sdo_rx_out.sv */
// receive video output port
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - drive transport frame-rate code, valid under lock
// - transport scan flag: low interlaced, high progressive
// - level flag high for level B input
// - sd enable averages 1 in 5.5, else high
// - sd stream and flags valid only on enable
// - new-alignment flag, pulse or held until realign
// - 11-bit link A line number from Y stream
// - stream 1 payload id, byte4 high, valid flag
// - stream 2 payload id, 3G only, valid flag
// - link A crc flag for previous line
// - crc flag changes six samples after eav
// - output recovered 10-bit data stream 1
// - output recovered 10-bit data stream 2
// - eav flag one sample on xyz word
// - sav flag one sample on xyz word
// - trs flag four samples, 3ff to xyz
// - level B second 11-bit line number
// - level B ready every other cycle, else high
// - level B second crc flag, same timing
// - drive transport lock once format identified
// - mode indicators low while unlocked
// - all outputs synchronous to receive clock
module sdo_rx_out #(
  parameter int WORD_W = 10,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [WORD_W-1:0] raw_word_a1,
  input wire logic [WORD_W-1:0] raw_word_a2,
  input wire logic [WORD_W-1:0] raw_word_b1,
  input wire logic [1:0] mode_code,
  input wire logic mode_locked,
  input wire logic level_b_detected,
  input wire logic transport_locked_in,
  input wire logic [3:0] transport_rate_in,
  input wire logic transport_scan_in,
  input wire logic frame_en,
  output logic sd_sample_enable,
  output logic level_b_output_ready,
  output logic triple_rate_mode_indicator,
  output logic mode_hd,
  output logic mode_sd,
  output logic triple_rate_level_b_flag,
  output logic transport_locked,
  output logic [3:0] transport_rate,
  output logic transport_scan,
  output logic new_alignment,
  output logic [WORD_W-1:0] recovered_stream_one,
  output logic [WORD_W-1:0] recovered_stream_two,
  output logic trs_flag,
  output logic eav_flag,
  output logic sav_flag,
  output logic [10:0] line_a,
  output logic [10:0] line_b,
  output logic [31:0] vpid_a,
  output logic vpid_a_valid,
  output logic [31:0] vpid_b,
  output logic vpid_b_valid,
  output logic crc_err_a,
  output logic crc_err_b
);

  // the alignment search and field slicing assume 10-bit words
  if (WORD_W != 10) $error("sdo_rx_out: WORD_W must be 10");
  if (ADDR_W < 5) $error("sdo_rx_out: ADDR_W must cover the register map");

  typedef struct packed {
    logic [3:0] ph;
    logic tog;
    logic [2:0][4:0][9:0] raw;
    logic [3:0] align;
    logic nsp;
    logic [2:0][3:0][9:0] sh;
    logic [2:0][9:0] ow;
    logic [2:0] cnt;
    logic hbit;
    logic trs;
    logic eav;
    logic sav;
    logic [2:0] pc;
    logic [1:0][9:0] ln0;
    logic [1:0][10:0] line;
    logic [1:0][17:0] crc;
    logic [1:0][8:0] crc0;
    logic [1:0] pend;
    logic [1:0] cerr;
    logic [1:0][5:0][9:0] hist;
    logic [1:0][2:0] vc;
    logic [1:0][31:0] vsh;
    logic [1:0][31:0] vpid;
    logic [1:0] vval;
    logic [2:0] md;
    logic levb;
    logic tlk;
    logic [3:0] trate;
    logic tscan;
    logic ctrl_fe;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sdo_state_s;

  sdo_state_s state_reg;
  sdo_state_s state_next;

  // crc-18 step, lsb first
  function automatic logic [17:0] sdo_crc_step(input logic [17:0] c, input logic [9:0] d);
    logic [17:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 10; i++)
    begin
      fb = r[0] ^ d[i];
      r = {1'b0, r[17:1]};
      if (fb)
      begin
        r = r ^ sdo_pkg::CRC_MASK;
      end
    end
    return r;
  endfunction : sdo_crc_step

  // sample qualifiers: sd cadence and level B half rate
  logic is_sd;
  logic is_levb;
  logic ce;
  logic rdy;
  logic adv;
  assign is_sd = mode_code == sdo_pkg::MODE_SD;
  assign is_levb = (mode_code == sdo_pkg::MODE_3G) && level_b_detected;
  assign ce = !is_sd || state_reg.ph == 4'h0 || state_reg.ph == sdo_pkg::SD_SECOND;
  assign rdy = !is_levb || state_reg.tog;
  assign adv = ce && rdy;

  // next-state logic for the whole block
  always_comb
  begin
    logic [49:0] win;
    logic found;
    logic [3:0] fo;
    logic fe;
    logic [5:0] base;
    logic [2:0][9:0] lw;
    logic [9:0] cw;
    logic aw_ok;
    logic ar_ok;
    logic [31:0] rd;
    logic [1:0] rr;
    win = '0;
    found = 1'b0;
    fo = 4'h0;
    fe = frame_en && state_reg.ctrl_fe;
    base = 6'h00;
    lw = '0;
    cw = 10'h000;
    rd = 32'h0000_0000;
    rr = sdo_pkg::RESP_OKAY;
    state_next = state_reg;

    // cadence counters run on every clock
    state_next.ph = (!is_sd || state_reg.ph == sdo_pkg::SD_PERIOD_LAST) ? 4'h0
                    : state_reg.ph + 4'h1;
    state_next.tog = is_levb ? !state_reg.tog : 1'b0;

    // mode indicators, forced low while unlocked; transport indicators registered ungated
    state_next.md[0] = mode_locked && mode_code == sdo_pkg::MODE_HD;
    state_next.md[1] = mode_locked && is_sd;
    state_next.md[2] = mode_locked && mode_code == sdo_pkg::MODE_3G;
    state_next.levb = mode_locked && is_levb;
    state_next.tlk = transport_locked_in;
    state_next.trate = transport_rate_in;
    state_next.tscan = transport_scan_in;

    // framer: find 3ff 000 000 at any offset
    win = {state_reg.raw[0][0], state_reg.raw[0][1], state_reg.raw[0][2],
           state_reg.raw[0][3], state_reg.raw[0][4]};
    for (int o = 9; o >= 0; o--)
    begin
      if (win[o +: 30] == {sdo_pkg::TRS_ZERO, sdo_pkg::TRS_ZERO, sdo_pkg::TRS_ONES})
      begin
        found = 1'b1;
        fo = 4'(o);
      end
    end

    if (adv)
    begin
      // raw history shift
      for (int s = 0; s < 3; s++)
      begin
        state_next.raw[s][0] = (s == 0) ? raw_word_a1 : (s == 1) ? raw_word_a2 : raw_word_b1;
        for (int k = 1; k < 5; k++)
        begin
          state_next.raw[s][k] = state_reg.raw[s][k-1];
        end
      end

      // new alignment flag: pulse with framing on, held otherwise
      if (fe)
      begin
        state_next.nsp = 1'b0;
      end
      if (found && fo != state_reg.align)
      begin
        state_next.nsp = 1'b1;
      end
      if (found && (fe || fo == state_reg.align))
      begin
        state_next.align = fo;
      end

      // aligned word pipelines; a trs reloads them at its own offset
      base = 6'(state_next.align);
      for (int s = 0; s < 3; s++)
      begin
        win = {state_reg.raw[s][0], state_reg.raw[s][1], state_reg.raw[s][2],
               state_reg.raw[s][3], state_reg.raw[s][4]};
        if (found && (fe || fo == state_reg.align))
        begin
          for (int k = 0; k < 4; k++)
          begin
            state_next.sh[s][3-k] = win[base + 6'(10 * k) +: 10];
          end
        end
        else
        begin
          state_next.sh[s][0] = win[base + 6'd30 +: 10];
          for (int k = 1; k < 4; k++)
          begin
            state_next.sh[s][k] = state_reg.sh[s][k-1];
          end
        end
        state_next.ow[s] = state_reg.sh[s][3];
      end

      // timing flags follow the reloaded trs words to the output
      state_next.trs = state_reg.cnt != 3'h0;
      state_next.eav = state_reg.cnt == 3'h1 && state_reg.hbit;
      state_next.sav = state_reg.cnt == 3'h1 && !state_reg.hbit;
      if (found && (fe || fo == state_reg.align))
      begin
        state_next.cnt = 3'h4;
        state_next.hbit = win[6'(fo) + 6'd30 + 6'(sdo_pkg::XYZ_H_BIT)];
      end
      else if (state_reg.cnt != 3'h0)
      begin
        state_next.cnt = state_reg.cnt - 3'h1;
      end

      // position after the eav sample on the output
      if (state_reg.cnt == 3'h1 && state_reg.hbit)
      begin
        state_next.pc = 3'h1;
      end
      else if (state_reg.pc == sdo_pkg::PC_ERR)
      begin
        state_next.pc = 3'h0;
      end
      else if (state_reg.pc != 3'h0)
      begin
        state_next.pc = state_reg.pc + 3'h1;
      end

      // per link: line number and crc check
      lw[0] = state_reg.sh[0][3];
      lw[1] = state_reg.sh[2][3];
      for (int l = 0; l < 2; l++)
      begin
        cw = lw[l];
        if (state_reg.pc == sdo_pkg::PC_LN0)
        begin
          state_next.ln0[l] = cw;
        end
        if (state_reg.pc == sdo_pkg::PC_LN1)
        begin
          state_next.line[l] = {cw[sdo_pkg::LN1_MSB:sdo_pkg::LN1_LSB],
                                state_reg.ln0[l][sdo_pkg::LN0_MSB:sdo_pkg::LN0_LSB]};
        end
        if (state_reg.pc == sdo_pkg::PC_CRC0)
        begin
          state_next.crc0[l] = cw[sdo_pkg::CRC_HALF-1:0];
        end
        else if (state_reg.pc == sdo_pkg::PC_CRC1)
        begin
          state_next.pend[l] = {cw[sdo_pkg::CRC_HALF-1:0], state_reg.crc0[l]}
                               != state_reg.crc[l];
          state_next.crc[l] = 18'h00000;
        end
        else
        begin
          state_next.crc[l] = sdo_crc_step(state_reg.crc[l], cw);
        end
        if (state_reg.pc == sdo_pkg::PC_ERR)
        begin
          state_next.cerr[l] = state_reg.pend[l];
        end
      end

      // payload id parsers
      lw[0] = state_reg.sh[0][3];
      lw[1] = is_levb ? state_reg.sh[2][3] : state_reg.sh[1][3];
      for (int l = 0; l < 2; l++)
      begin
        cw = lw[l];
        state_next.hist[l][0] = cw;
        for (int k = 1; k < 6; k++)
        begin
          state_next.hist[l][k] = state_reg.hist[l][k-1];
        end
        if (state_reg.hist[l][5] == sdo_pkg::TRS_ZERO && state_reg.hist[l][4] == sdo_pkg::TRS_ONES
            && state_reg.hist[l][3] == sdo_pkg::TRS_ONES
            && state_reg.hist[l][2][7:0] == sdo_pkg::ANC_DID
            && state_reg.hist[l][1][7:0] == sdo_pkg::ANC_SDID
            && state_reg.hist[l][0][7:0] == sdo_pkg::ANC_DC)
        begin
          state_next.vc[l] = 3'h1;
          state_next.vsh[l] = {cw[7:0], state_reg.vsh[l][31:8]};
        end
        else if (state_reg.vc[l] != 3'h0 && state_reg.vc[l] != sdo_pkg::VPID_BYTES)
        begin
          state_next.vc[l] = state_reg.vc[l] + 3'h1;
          state_next.vsh[l] = {cw[7:0], state_reg.vsh[l][31:8]};
        end
        else if (state_reg.vc[l] == sdo_pkg::VPID_BYTES)
        begin
          state_next.vc[l] = 3'h0;
          state_next.vpid[l] = state_reg.vsh[l];
          state_next.vval[l] = 1'b1;
        end
      end
    end

    // payload id valid needs lock
    if (!mode_locked)
    begin
      state_next.vval = 2'b00;
    end
    if (mode_code != sdo_pkg::MODE_3G)
    begin
      state_next.vval[1] = 1'b0;
    end

    // axi4-lite write
    aw_ok = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
    if (aw_ok)
    begin
      state_next.bvalid = 1'b1;
      state_next.bresp = sdo_pkg::RESP_DECERR;
      if (s_axi_awaddr[7:0] == sdo_pkg::REG_CTRL)
      begin
        state_next.bresp = sdo_pkg::RESP_OKAY;
        if (s_axi_wstrb[0])
        begin
          state_next.ctrl_fe = s_axi_wdata[sdo_pkg::CTRL_FRAME_BIT];
        end
      end
      else if (s_axi_awaddr[7:0] == sdo_pkg::REG_STATUS || s_axi_awaddr[7:0] == sdo_pkg::REG_LINE
               || s_axi_awaddr[7:0] == sdo_pkg::REG_VPID_A
               || s_axi_awaddr[7:0] == sdo_pkg::REG_VPID_B)
      begin
        state_next.bresp = sdo_pkg::RESP_OKAY;
      end
    end
    else if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end

    // axi4-lite read
    ar_ok = s_axi_arvalid && !state_reg.rvalid;
    case (s_axi_araddr[7:0])
      sdo_pkg::REG_CTRL: rd[sdo_pkg::CTRL_FRAME_BIT] = state_reg.ctrl_fe;
      sdo_pkg::REG_STATUS:
      begin
        rd[sdo_pkg::ST_MLOCK] = mode_locked;
        rd[sdo_pkg::ST_TLOCK] = state_reg.tlk;
        rd[sdo_pkg::ST_MODE_LSB +: 2] = mode_code;
        rd[sdo_pkg::ST_LEVB] = state_reg.levb;
        rd[sdo_pkg::ST_NSP] = state_reg.nsp;
        rd[sdo_pkg::ST_CRCA] = crc_err_a;
        rd[sdo_pkg::ST_CRCB] = crc_err_b;
        rd[sdo_pkg::ST_VVA] = state_reg.vval[0];
        rd[sdo_pkg::ST_VVB] = state_reg.vval[1];
      end
      sdo_pkg::REG_LINE:
      begin
        rd[10:0] = state_reg.line[0];
        rd[sdo_pkg::LINE_B_LSB +: 11] = state_reg.line[1];
      end
      sdo_pkg::REG_VPID_A: rd = state_reg.vpid[0];
      sdo_pkg::REG_VPID_B: rd = state_reg.vpid[1];
      default: rr = sdo_pkg::RESP_DECERR;
    endcase
    if (ar_ok)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd;
      state_next.rresp = rr;
    end
    else if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.ctrl_fe <= sdo_pkg::CTRL_FRAME_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bus handshakes
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
  assign s_axi_wready = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // video outputs
  assign sd_sample_enable = ce;
  assign level_b_output_ready = rdy;
  assign mode_hd = state_reg.md[0];
  assign mode_sd = state_reg.md[1];
  assign triple_rate_mode_indicator = state_reg.md[2];
  assign triple_rate_level_b_flag = state_reg.levb;
  assign transport_locked = state_reg.tlk;
  assign transport_rate = state_reg.trate;
  assign transport_scan = state_reg.tscan;
  assign new_alignment = state_reg.nsp;
  assign recovered_stream_one = state_reg.ow[0];
  assign recovered_stream_two = state_reg.ow[1];
  assign trs_flag = state_reg.trs;
  assign eav_flag = state_reg.eav;
  assign sav_flag = state_reg.sav;
  assign line_a = state_reg.line[0];
  assign line_b = state_reg.line[1];
  assign vpid_a = state_reg.vpid[0];
  assign vpid_a_valid = state_reg.vval[0];
  assign vpid_b = state_reg.vpid[1];
  assign vpid_b_valid = state_reg.vval[1];
  // crc flags: link A outside sd, link B only in level B
  assign crc_err_a = state_reg.cerr[0] && !is_sd;
  assign crc_err_b = state_reg.cerr[1] && is_levb;

endmodule : sdo_rx_out
`default_nettype wire

/* File: verif/sdo_rx_out_checker.sv */
// concurrent checks on the receive video output port
`timescale 1ns/1ps
`default_nettype none
module sdo_rx_out_checker #(
  parameter int WORD_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode_code,
  input wire logic mode_locked,
  input wire logic level_b_detected,
  input wire logic transport_locked_in,
  input wire logic [3:0] transport_rate_in,
  input wire logic transport_scan_in,
  input wire logic sd_sample_enable,
  input wire logic level_b_output_ready,
  input wire logic triple_rate_mode_indicator,
  input wire logic mode_hd,
  input wire logic triple_rate_level_b_flag,
  input wire logic transport_locked,
  input wire logic [3:0] transport_rate,
  input wire logic transport_scan,
  input wire logic [WORD_W-1:0] recovered_stream_one,
  input wire logic trs_flag,
  input wire logic eav_flag,
  input wire logic sav_flag,
  input wire logic vpid_a_valid,
  input wire logic vpid_b_valid,
  input wire logic crc_err_a
);
  logic hd;
  logic lvb;
  // mode decodes of the inputs
  assign hd = mode_code == sdo_pkg::MODE_HD;
  assign lvb = mode_code == sdo_pkg::MODE_3G && level_b_detected;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_trs_run;
    trs_flag [*4] ##1 !trs_flag;
  endsequence
  sequence s_xyz_tail;
    trs_flag && $past(trs_flag, 3);
  endsequence
  property p_trs;
    $rose(trs_flag) && hd |-> s_trs_run;
  endproperty
  property p_eav;
    eav_flag && hd |-> s_xyz_tail ##0 recovered_stream_one[6] && !sav_flag ##1 !eav_flag;
  endproperty
  property p_sav;
    sav_flag && hd |-> s_xyz_tail ##0 !recovered_stream_one[6] ##1 !sav_flag;
  endproperty
  property p_sd_on;
    mode_code != sdo_pkg::MODE_SD |-> sd_sample_enable;
  endproperty
  property p_sd_gap;
    sd_sample_enable && mode_code == sdo_pkg::MODE_SD && $past(mode_code) == sdo_pkg::MODE_SD
      |=> (!sd_sample_enable || mode_code != sdo_pkg::MODE_SD) [*4] ##[1:2] sd_sample_enable;
  endproperty
  property p_rdy_on;
    !lvb |-> level_b_output_ready;
  endproperty
  property p_rdy_alt;
    lvb && $past(lvb) && $past(aresetn) |-> level_b_output_ready != $past(level_b_output_ready);
  endproperty
  property p_trans;
    $past(aresetn) |-> transport_locked == $past(transport_locked_in)
      && transport_rate == $past(transport_rate_in) && transport_scan == $past(transport_scan_in);
  endproperty
  property p_mode;
    $past(aresetn) |-> triple_rate_mode_indicator == $past(mode_locked && mode_code == 2'h2)
      && triple_rate_level_b_flag == $past(mode_locked && lvb) && mode_hd == $past(mode_locked && hd);
  endproperty
  property p_vpid;
    !mode_locked |=> !vpid_a_valid && !vpid_b_valid;
  endproperty
  property p_crc;
    $changed(crc_err_a) && hd && $past(hd) && $past(aresetn) |-> $past(eav_flag, 6);
  endproperty
  a_trs: assert property (p_trs) else $error("trs run");
  a_eav: assert property (p_eav) else $error("bad eav");
  a_sav: assert property (p_sav) else $error("bad sav");
  a_sd_on: assert property (p_sd_on) else $error("enable low");
  a_sd_gap: assert property (p_sd_gap) else $error("sd spacing");
  a_rdy_on: assert property (p_rdy_on) else $error("ready low");
  a_rdy_alt: assert property (p_rdy_alt) else $error("ready stuck");
  a_trans: assert property (p_trans) else $error("bad transport");
  a_mode: assert property (p_mode) else $error("bad modes");
  a_vpid: assert property (p_vpid) else $error("valid unlocked");
  a_crc: assert property (p_crc) else $error("crc slot");
endmodule : sdo_rx_out_checker
bind sdo_rx_out sdo_rx_out_checker #(.WORD_W(WORD_W)) sdo_rx_out_checker_inst (.*);
`default_nettype wire

/* File: verif/sdo_video_sink.sv */
// downstream consumer model that samples the recovered stream
`timescale 1ns/1ps
`default_nettype none
module sdo_video_sink (
  input wire logic aclk,
  input wire logic sd_sample_enable,
  input wire logic level_b_output_ready,
  input wire logic [9:0] recovered_stream_one,
  input wire logic trs_flag,
  input wire logic eav_flag,
  output var int trs_cnt,
  output var int eav_cnt,
  output logic [9:0] eav_word
);
  // take outputs only on qualified samples
  always @(posedge aclk)
  begin
    if (sd_sample_enable === 1'b1 && level_b_output_ready === 1'b1)
    begin
      if (trs_flag === 1'b1)
        trs_cnt <= trs_cnt + 1;
      if (eav_flag === 1'b1)
      begin
        eav_cnt <= eav_cnt + 1;
        eav_word <= recovered_stream_one;
      end
    end
  end
endmodule : sdo_video_sink
`default_nettype wire

/* File: verif/sdo_rx_out_tb.sv */
// self-checking testbench of the receive video output port
`timescale 1ns/1ps
`default_nettype none
module sdo_rx_out_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, vpid_a, vpid_b, rd;
  logic [9:0] raw_word_a1 = 10'h040, raw_word_a2 = 10'h040, raw_word_b1 = 10'h040;
  logic [1:0] mode_code = 2'h0;
  logic mode_locked = 1'b0, level_b_detected = 1'b0, transport_locked_in = 1'b0;
  logic [3:0] transport_rate_in = 4'h0, transport_rate;
  logic transport_scan_in = 1'b0, frame_en = 1'b1;
  logic sd_sample_enable, level_b_output_ready, triple_rate_mode_indicator, mode_hd, mode_sd;
  logic triple_rate_level_b_flag, transport_locked, transport_scan, new_alignment;
  logic [9:0] recovered_stream_one, recovered_stream_two, eav_word;
  logic trs_flag, eav_flag, sav_flag, vpid_a_valid, vpid_b_valid, crc_err_a, crc_err_b;
  logic [10:0] line_a, line_b;
  int trs_cnt, eav_cnt, n;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  sdo_rx_out sdo_rx_out_inst (.*);
  sdo_video_sink sdo_video_sink_inst (.*);
  // free-running clock
  always #5 aclk = ~aclk;
  // cut a hung run short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(negedge aclk);
    while (s_axi_bvalid !== 1'b1) @(negedge aclk);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    while (s_axi_arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (s_axi_rvalid !== 1'b1) @(negedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axr
  // one word on every raw lane, held until a sample takes it
  task automatic tx(input logic [9:0] w);
    raw_word_a1 <= w;
    raw_word_a2 <= w;
    raw_word_b1 <= w;
    @(negedge aclk);
    while (!(sd_sample_enable && level_b_output_ready)) @(negedge aclk);
    @(posedge aclk);
  endtask : tx
  // eav, line number, crc, payload id packet, sav, then filler to flush
  task automatic send_line(input logic [10:0] ln, input logic [31:0] id);
    logic [9:0] w [23];
    w = '{10'h3ff, 10'h000, 10'h000, 10'h274, {~ln[6], ln[6:0], 2'h0}, {4'h8, ln[10:7], 2'h0},
      10'h200, 10'h200, 10'h000, 10'h3ff, 10'h3ff, 10'h241, 10'h101, 10'h104, {2'h2, id[7:0]},
      {2'h2, id[15:8]}, {2'h2, id[23:16]}, {2'h2, id[31:24]}, 10'h200, 10'h3ff, 10'h000,
      10'h000, 10'h200};
    foreach (w[i]) tx(w[i]);
    repeat (10) tx(10'h040);
  endtask : send_line
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // register reset values, read-only and unmapped places
    axr(sdo_pkg::REG_CTRL, rd, rsp);
    chk("ctrl reset", {rd, rsp}, {32'h1, sdo_pkg::RESP_OKAY});
    axr(8'h14, rd, rsp);
    chk("unmapped read", {rd[29:0], rsp}, {30'h0, sdo_pkg::RESP_DECERR});
    axw(8'h14, 32'h1, rsp);
    chk("unmapped write", rsp, sdo_pkg::RESP_DECERR);
    axw(sdo_pkg::REG_STATUS, 32'hffff_ffff, rsp);
    axr(sdo_pkg::REG_STATUS, rd, rsp);
    chk("status", rd, 32'h0);
    axw(sdo_pkg::REG_CTRL, 32'h0, rsp);
    axr(sdo_pkg::REG_CTRL, rd, rsp);
    chk("ctrl write", rd, 32'h0);
    axw(sdo_pkg::REG_CTRL, 32'h1, rsp);
    $display("test registers done");
    transport_locked_in <= 1'b1;
    transport_rate_in <= 4'ha;
    transport_scan_in <= 1'b1;
    mode_locked <= 1'b1;
    send_line(11'h465, 32'h44332211);
    send_line(11'h465, 32'h44332211);
    @(negedge aclk);
    chk("transport", {transport_locked, transport_rate, transport_scan}, 6'h35);
    chk("hd ind", {mode_hd, triple_rate_mode_indicator, mode_sd}, 3'h4);
    chk("line a", line_a, 11'h465);
    chk("vpid a", {vpid_a_valid, vpid_b_valid, vpid_a}, {2'h2, 32'h44332211});
    chk("crc a", crc_err_a, 1'b1);
    chk("eav word", eav_word, 10'h274);
    chk("trs count", trs_cnt, 16);
    @(posedge aclk);
    axr(sdo_pkg::REG_LINE, rd, rsp);
    chk("line reg", rd[10:0], 11'h465);
    $display("test hd done");
    mode_code <= sdo_pkg::MODE_3G;
    send_line(11'h2b3, 32'h8a7b6c5d);
    @(negedge aclk);
    chk("3g ind", {triple_rate_mode_indicator, triple_rate_level_b_flag}, 2'h2);
    chk("vpid b", {vpid_b_valid, vpid_b}, {1'b1, 32'h8a7b6c5d});
    @(posedge aclk);
    level_b_detected <= 1'b1;
    send_line(11'h5a1, 32'h01020304);
    send_line(11'h5a1, 32'h01020304);
    @(negedge aclk);
    chk("level b", triple_rate_level_b_flag, 1'b1);
    chk("lines", {line_a, line_b}, {2{11'h5a1}});
    chk("vpid b level b", vpid_b, 32'h01020304);
    chk("crc b", crc_err_b, 1'b1);
    chk("eav count", eav_cnt, 5);
    @(posedge aclk);
    $display("test 3g done");
    mode_code <= sdo_pkg::MODE_SD;
    n = 0;
    repeat (22)
    begin
      @(negedge aclk);
      n += int'(sd_sample_enable);
    end
    chk("sd enables", n, 4);
    @(posedge aclk);
    send_line(11'h001, 32'h0);
    @(negedge aclk);
    chk("sd eav", eav_cnt, 6);
    chk("sd ind", mode_sd, 1'b1);
    @(posedge aclk);
    $display("test sd done");
    mode_locked <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("unlocked", {mode_sd, vpid_a_valid}, 2'h0);
    @(posedge aclk);
    axr(sdo_pkg::REG_STATUS, rd, rsp);
    chk("status unlocked", rd[3:0], 4'h6);
    $display("test unlock done");
    stop_test();
  end
endmodule : sdo_rx_out_tb
`default_nettype wire
